// >>> radio_link_cfg.svh
// Constants for the radio channel configuration link
`ifndef RADIO_LINK_CFG_SVH
`define RADIO_LINK_CFG_SVH

// Timing
`define CLK_HZ      100000000
`define BAUD        2400
`define BIT_CYC     (`CLK_HZ / `BAUD)
`define PROG_MS     50
`define PROG_CYC    (`PROG_MS * (`CLK_HZ / 1000))

// Argument limits
`define CH_MAX      17'h0001F
`define N_MAX       17'h0FFFF
`define R_MAX       17'h03FFF

// Factory divider values
`define N_CH0_TX    16'h1B12
`define N_CH0_RX    16'h17BA
`define R_TX        14'h0190
`define R_RX        14'h0208

// Characters and keywords
`define CHR_CR      8'h0D
`define CHR_SP      8'h20
`define CHR_HASH    8'h23
`define CHR_SLASH   8'h2F
`define UNLOCK_TXT  128'h454E41424C4553455249414C4D4F4445
`define KW_SER_CHAN 48'h474F4348414E
`define KW_STORE    48'h00004C4F4144
`define KW_PAR_SEL  48'h534554504152
`define KW_SER_SEL  48'h534554534552
`define KW_REF_DIV  48'h5256414C5545
`define KW_SINGLE   48'h53494E474C45

// Host register offsets and fields
`define REG_CMD     4'h0
`define REG_ARG     4'h4
`define REG_PINS    4'h8
`define REG_STATUS  4'hC
`define ARG_VAL_LSB 8
`define PIN_EN_BIT  4
`define PIN_SER_BIT 5
`define PINS_RST    6'h1F

`endif

// >>> radio_link_pkg.sv
// Types shared by both ends of the radio channel configuration link
package radio_link_pkg;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } rx_state_t;

  typedef enum logic [1:0] {
    MODE_PAR    = 2'b00,
    MODE_SER    = 2'b01,
    MODE_SINGLE = 2'b10
  } chan_mode_t;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_SEND  = 2'b01,
    TX_PAUSE = 2'b10
  } tx_state_t;

  typedef enum logic [3:0] {
    CMD_UNLOCK       = 4'h0,
    CMD_SER_CHAN     = 4'h1,
    CMD_STORE        = 4'h2,
    CMD_PAR_SEL      = 4'h3,
    CMD_SER_SEL      = 4'h4,
    CMD_REF_DIV      = 4'h5,
    CMD_SINGLE       = 4'h6,
    CMD_LOCK         = 4'h7,
    CMD_CLEAR        = 4'h8
  } cmd_kind_t;

  typedef struct packed {
    logic [47:0] kw;
    logic [2:0]  kw_len;
    logic [1:0]  field;
    logic [16:0] acc_a;
    logic [2:0]  cnt_a;
    logic [16:0] acc_b;
    logic [2:0]  cnt_b;
    logic        bad;
  } line_t;

  typedef struct packed {
    logic [5:0]        sync1;
    logic [5:0]        sync2;
    logic [5:0]        sync3;
    logic [5:0]        lvl;
    rx_state_t         rx_st;
    logic [16:0]       tmr;
    logic [2:0]        bit_idx;
    logic [7:0]        sh;
    logic [4:0]        unlock_idx;
    logic              cmd_on;
    line_t             ln;
    logic [31:0][15:0] nv;
    chan_mode_t        mode;
    logic [4:0]        ser_chan;
    logic [13:0]       r_val;
    logic [15:0]       single_n;
    logic              single_ok;
    logic [23:0]       prog;
    logic [4:0]        out_chan;
    logic [15:0]       out_n;
    logic [13:0]       out_r;
    logic              out_on;
  } dev_state_t;

  typedef struct packed {
    tx_state_t   st;
    logic [135:0] line;
    logic [4:0]  left;
    logic [3:0]  pos;
    logic [16:0] tmr;
    logic [23:0] pause;
    logic [3:0]  kind;
    logic [27:0] arg;
    logic [5:0]  pin_cfg;
    logic        ack;
    logic [31:0] dat;
    logic [5:0]  pin_out;
  } host_state_t;

endpackage : radio_link_pkg

// >>> radio_link_if.sv
// Pins between the channel configuration host and the radio module
`timescale 1ns/1ns
`default_nettype none
interface radio_link_if;
  logic chan_sel0_prog_in;
  logic chan_sel1;
  logic chan_sel2;
  logic chan_sel3;
  logic transmit_enable_n;
  logic receive_enable;

  modport device (
    input chan_sel0_prog_in, chan_sel1, chan_sel2, chan_sel3,
    input transmit_enable_n, receive_enable
  );
  modport host (
    output chan_sel0_prog_in, chan_sel1, chan_sel2, chan_sel3,
    output transmit_enable_n, receive_enable
  );
endinterface : radio_link_if
`default_nettype wire

// >>> radio_link_device.sv
// Radio module end: serial command interpreter and channel selection
//
// The implementer's own choices: the Wishbone interface to the registers and the register offsets.
`include "radio_link_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module radio_link_device
  import radio_link_pkg::*;
#(
  parameter bit          IS_TX    = 1'b1,
  parameter int          BIT_CYC  = `BIT_CYC,
  parameter int          PROG_CYC = `PROG_CYC,
  parameter logic [15:0] N_CH0    = IS_TX ? `N_CH0_TX : `N_CH0_RX,
  parameter logic [13:0] R_FACT   = IS_TX ? `R_TX : `R_RX
) (
  input  wire logic  clk_i,
  input  wire logic  rst_i,
  input  wire logic  factory_load_i,
  radio_link_if.device link,
  output logic [4:0] channel_o,
  output logic [15:0] n_div_o,
  output logic [13:0] r_div_o,
  output logic       operative_o,
  output logic       cmd_mode_o,
  output logic       prog_busy_o
);

  localparam logic [16:0] BIT_LAST  = 17'(BIT_CYC - 1);
  localparam logic [16:0] HALF_LAST = 17'(BIT_CYC / 2 - 1);
  // Unlock phrase as a named constant so that single characters can be selected
  localparam logic [127:0] UNLOCK   = `UNLOCK_TXT;

  dev_state_t  s_q;
  dev_state_t  s_d;
  logic [5:0]  pins;
  logic        rx_bit;
  logic        byte_v;
  logic [7:0]  ch;
  logic        enabled;
  logic        go;
  logic [4:0]  par_chan;
  logic [4:0]  cur_chan;
  logic [16:0] acc_n;

  // Two-digit channel number within 00..31
  function automatic logic chan_ok(input logic [16:0] acc, input logic [2:0] cnt);
    chan_ok = (cnt == 3'h2) && (acc <= `CH_MAX);
  endfunction : chan_ok

  // Decimal value of one to five digits within a limit
  function automatic logic val_ok(input logic [16:0] acc, input logic [2:0] cnt,
                                  input logic [16:0] lim);
    val_ok = (cnt != 3'h0) && (acc <= lim);
  endfunction : val_ok

  // Factory channel table built from the channel 0 divider
  function automatic logic [31:0][15:0] factory_table(input logic [15:0] base);
    logic [31:0][15:0] t;
    t = '0;
    for (int c = 0; c < 32; c++) begin
      if (c < 4) begin
        t[c] = base + 16'(c);
      end else if (c < 8) begin
        t[c] = base - 16'h0001;
      end else begin
        t[c] = base + 16'h0003;
      end
    end
    factory_table = t;
  endfunction : factory_table

  // Raw pins: [5] rx enable, [4] tx enable, [3:0] select
  assign pins = {link.receive_enable, link.transmit_enable_n, link.chan_sel3,
                 link.chan_sel2, link.chan_sel1, link.chan_sel0_prog_in};

  // Whole next-state computation
  always_comb begin
    s_d    = s_q;
    byte_v = 1'b0;
    go     = 1'b0;
    acc_n  = '0;
    ch     = s_q.sh;

    // Three-stage synchronisers, a change counts once stages two and three agree
    s_d.sync1 = pins;
    s_d.sync2 = s_q.sync1;
    s_d.sync3 = s_q.sync2;
    s_d.lvl   = (s_q.sync2 & s_q.sync3) | (s_q.lvl & (s_q.sync2 ^ s_q.sync3));

    rx_bit   = ~s_q.lvl[0];
    par_chan = {1'b0, ~s_q.lvl[3:0]};
    enabled  = IS_TX ? ~s_q.lvl[4] : s_q.lvl[5];

    // Asynchronous receiver, mid-bit sampling
    unique case (s_q.rx_st)
      RX_IDLE: begin
        s_d.tmr = '0;
        if (!rx_bit) begin
          s_d.rx_st = RX_START;
        end
      end
      RX_START: begin
        s_d.tmr = s_q.tmr + 17'h00001;
        if (s_q.tmr == HALF_LAST) begin
          s_d.tmr     = '0;
          s_d.bit_idx = '0;
          s_d.rx_st   = rx_bit ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA: begin
        s_d.tmr = s_q.tmr + 17'h00001;
        if (s_q.tmr == BIT_LAST) begin
          s_d.tmr     = '0;
          s_d.sh      = {rx_bit, s_q.sh[7:1]};
          s_d.bit_idx = s_q.bit_idx + 3'h1;
          if (s_q.bit_idx == 3'h7) begin
            s_d.rx_st = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        s_d.tmr = s_q.tmr + 17'h00001;
        if (s_q.tmr == BIT_LAST) begin
          // Back to idle mid-stop, so a second stop bit is simply idle line
          s_d.rx_st = RX_IDLE;
          byte_v    = rx_bit;
        end
      end
    endcase

    // Command interpreter
    if (byte_v) begin
      if (!s_q.cmd_on) begin
        if (s_q.unlock_idx == 5'h10 && ch == `CHR_CR) begin
          s_d.cmd_on     = 1'b1;
          s_d.unlock_idx = '0;
          s_d.ln         = '0;
        end else if (s_q.unlock_idx != 5'h10 &&
                     ch == UNLOCK[8'(127 - 8 * s_q.unlock_idx) -: 8]) begin
          s_d.unlock_idx = s_q.unlock_idx + 5'h01;
        end else begin
          s_d.unlock_idx = (ch == UNLOCK[127:120]) ? 5'h01 : 5'h00;
        end
      end else if (ch == `CHR_HASH) begin
        s_d.cmd_on = 1'b0;
        s_d.ln     = '0;
      end else if (ch == `CHR_SLASH) begin
        s_d.ln = '0;
      end else if (ch == `CHR_CR) begin
        go     = enabled && !s_q.ln.bad;
        s_d.ln = '0;
      end else if (ch == `CHR_SP) begin
        if (s_q.ln.field == 2'h3) begin
          s_d.ln.bad = 1'b1;
        end else begin
          s_d.ln.field = s_q.ln.field + 2'h1;
        end
      end else if (s_q.ln.field == 2'h0) begin
        if (s_q.ln.kw_len == 3'h6) begin
          s_d.ln.bad = 1'b1;
        end else begin
          s_d.ln.kw     = {s_q.ln.kw[39:0], ch};
          s_d.ln.kw_len = s_q.ln.kw_len + 3'h1;
        end
      end else if (ch >= 8'h30 && ch <= 8'h39 && s_q.ln.field != 2'h3) begin
        // Decimal accumulation, five digits at most
        if (s_q.ln.field == 2'h1) begin
          acc_n = 17'(s_q.ln.acc_a * 17'h0000A + {13'h0, ch[3:0]});
          s_d.ln.bad   = s_q.ln.bad | (s_q.ln.cnt_a == 3'h5);
          s_d.ln.acc_a = acc_n;
          s_d.ln.cnt_a = s_q.ln.cnt_a + 3'h1;
        end else begin
          acc_n = 17'(s_q.ln.acc_b * 17'h0000A + {13'h0, ch[3:0]});
          s_d.ln.bad   = s_q.ln.bad | (s_q.ln.cnt_b == 3'h5);
          s_d.ln.acc_b = acc_n;
          s_d.ln.cnt_b = s_q.ln.cnt_b + 3'h1;
        end
      end else begin
        s_d.ln.bad = 1'b1;
      end
    end

    // Programming pause counter
    if (s_q.prog != 24'h000000) begin
      s_d.prog = s_q.prog - 24'h000001;
    end

    // Execution of a complete line; anything unmatched is dropped
    if (go) begin
      if (s_q.ln.kw == `KW_SER_CHAN && s_q.ln.field == 2'h1 &&
          chan_ok(s_q.ln.acc_a, s_q.ln.cnt_a)) begin
        s_d.ser_chan = s_q.ln.acc_a[4:0];
        s_d.mode     = MODE_SER;
        s_d.prog     = 24'(PROG_CYC);
      end else if (s_q.ln.kw == `KW_STORE && s_q.ln.field == 2'h2 &&
                   chan_ok(s_q.ln.acc_a, s_q.ln.cnt_a) &&
                   val_ok(s_q.ln.acc_b, s_q.ln.cnt_b, `N_MAX)) begin
        s_d.nv[s_q.ln.acc_a[4:0]] = s_q.ln.acc_b[15:0];
        s_d.prog                  = 24'(PROG_CYC);
      end else if (s_q.ln.kw == `KW_PAR_SEL && s_q.ln.field == 2'h0) begin
        s_d.mode = MODE_PAR;
        s_d.prog = 24'(PROG_CYC);
      end else if (s_q.ln.kw == `KW_SER_SEL && s_q.ln.field == 2'h0) begin
        s_d.mode = MODE_SER;
        s_d.prog = 24'(PROG_CYC);
      end else if (s_q.ln.kw == `KW_REF_DIV && s_q.ln.field == 2'h1 &&
                   val_ok(s_q.ln.acc_a, s_q.ln.cnt_a, `R_MAX)) begin
        s_d.r_val = s_q.ln.acc_a[13:0];
        s_d.prog  = 24'(PROG_CYC);
      end else if (s_q.ln.kw == `KW_SINGLE && s_q.ln.field == 2'h1 &&
                   val_ok(s_q.ln.acc_a, s_q.ln.cnt_a, `N_MAX)) begin
        s_d.single_n  = s_q.ln.acc_a[15:0];
        s_d.single_ok = 1'b1;
        s_d.mode      = MODE_SINGLE;
      end
    end

    // Operating channel and dividers
    unique case (s_q.mode)
      MODE_PAR:    cur_chan = par_chan;
      MODE_SER:    cur_chan = s_q.ser_chan;
      MODE_SINGLE: cur_chan = s_q.ser_chan;
      default:     cur_chan = par_chan;
    endcase
    s_d.out_chan = cur_chan;
    s_d.out_n    = (s_q.mode == MODE_SINGLE) ? s_q.single_n : s_q.nv[cur_chan];
    s_d.out_r    = s_q.r_val;
    s_d.out_on   = enabled && (s_q.mode != MODE_SINGLE || s_q.single_ok);

    // Factory defaults for the stored settings
    if (factory_load_i) begin
      s_d.nv       = factory_table(N_CH0);
      s_d.mode     = MODE_PAR;
      s_d.ser_chan = '0;
      s_d.r_val    = R_FACT;
    end

    // Power loss clears volatile state only, stored settings survive
    if (rst_i) begin
      // Pull-up idle levels, so release shows no false enable or select edge
      s_d.sync1      = `PINS_RST;
      s_d.sync2      = `PINS_RST;
      s_d.sync3      = `PINS_RST;
      s_d.lvl        = `PINS_RST;
      s_d.rx_st      = RX_IDLE;
      s_d.tmr        = '0;
      s_d.bit_idx    = '0;
      s_d.sh         = '0;
      s_d.unlock_idx = '0;
      s_d.cmd_on     = 1'b0;
      s_d.ln         = '0;
      s_d.single_ok  = 1'b0;
      s_d.prog       = '0;
      s_d.out_chan   = '0;
      s_d.out_n      = '0;
      s_d.out_r      = '0;
      s_d.out_on     = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    s_q <= s_d;
  end

  assign channel_o   = s_q.out_chan;
  assign n_div_o     = s_q.out_n;
  assign r_div_o     = s_q.out_r;
  assign operative_o = s_q.out_on;
  assign cmd_mode_o  = s_q.cmd_on;
  assign prog_busy_o = (s_q.prog != 24'h000000);

endmodule : radio_link_device
`default_nettype wire

// >>> radio_link_host.sv
// Host end: Wishbone-controlled command sender and channel pin driver
`include "radio_link_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module radio_link_host
  import radio_link_pkg::*;
#(
  parameter int BIT_CYC   = `BIT_CYC,
  parameter int PAUSE_CYC = `PROG_CYC,
  parameter int STOP_BITS = 2
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  radio_link_if.host       link
);

  localparam logic [16:0] BIT_LAST = 17'(BIT_CYC - 1);
  localparam logic [3:0]  POS_LAST = 4'(8 + STOP_BITS);
  localparam logic [47:0] KW_LOAD  = `KW_STORE;

  host_state_t s_q;
  host_state_t s_d;
  logic        acc;
  logic        tx;
  logic [31:0] wmask;

  // Five packed BCD digits as ASCII
  function automatic logic [39:0] digits5(input logic [19:0] v);
    digits5 = {4'h3, v[19:16], 4'h3, v[15:12], 4'h3, v[11:8], 4'h3, v[7:4],
               4'h3, v[3:0]};
  endfunction : digits5

  // Command line, left-aligned, with its length in characters
  function automatic logic [140:0] build_line(input logic [3:0] k, input logic [27:0] a);
    logic [15:0] cd;
    logic [39:0] vd;
    cd = {4'h3, a[7:4], 4'h3, a[3:0]};
    vd = digits5(a[27:8]);
    unique case (k)
      CMD_UNLOCK:   build_line = {5'h11, `UNLOCK_TXT, `CHR_CR};
      CMD_SER_CHAN: build_line = {5'h0A, `KW_SER_CHAN, `CHR_SP, cd, `CHR_CR, 56'h0};
      CMD_STORE:    build_line = {5'h0E, KW_LOAD[31:0], `CHR_SP, cd, `CHR_SP, vd,
                                  `CHR_CR, 24'h0};
      CMD_PAR_SEL:  build_line = {5'h07, `KW_PAR_SEL, `CHR_CR, 80'h0};
      CMD_SER_SEL:  build_line = {5'h07, `KW_SER_SEL, `CHR_CR, 80'h0};
      CMD_REF_DIV:  build_line = {5'h0D, `KW_REF_DIV, `CHR_SP, vd, `CHR_CR, 32'h0};
      CMD_SINGLE:   build_line = {5'h0D, `KW_SINGLE, `CHR_SP, vd, `CHR_CR, 32'h0};
      CMD_LOCK:     build_line = {5'h01, `CHR_HASH, 128'h0};
      CMD_CLEAR:    build_line = {5'h01, `CHR_SLASH, 128'h0};
      default:      build_line = '0;
    endcase
  endfunction : build_line

  // Whole next-state computation
  always_comb begin
    s_d   = s_q;
    acc   = wb_cyc_i && wb_stb_i && !s_q.ack;
    wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    tx    = 1'b1;

    // Wishbone slave, answer one cycle after the request
    s_d.ack = acc;
    if (acc && !wb_we_i) begin
      unique case (wb_adr_i)
        `REG_CMD:    s_d.dat = {28'h0, s_q.kind};
        `REG_ARG:    s_d.dat = {4'h0, s_q.arg};
        `REG_PINS:   s_d.dat = {26'h0, s_q.pin_cfg};
        `REG_STATUS: s_d.dat = {29'h0, s_q.st, s_q.st != TX_IDLE};
        default:     s_d.dat = '0;
      endcase
    end
    if (acc && wb_we_i) begin
      unique case (wb_adr_i)
        `REG_CMD: begin
          if (s_q.st == TX_IDLE && wb_sel_i[0]) begin
            s_d.kind              = wb_dat_i[3:0];
            {s_d.left, s_d.line}  = build_line(wb_dat_i[3:0], s_q.arg);
            s_d.st                = TX_SEND;
            s_d.pos               = '0;
            s_d.tmr               = '0;
          end
        end
        `REG_ARG:  s_d.arg = (s_q.arg & ~wmask[27:0]) | (wb_dat_i[27:0] & wmask[27:0]);
        `REG_PINS: s_d.pin_cfg = (s_q.pin_cfg & ~wmask[5:0]) | (wb_dat_i[5:0] & wmask[5:0]);
        default: ;
      endcase
    end

    // Serial transmitter, start bit, eight data bits LSB first, stop bits
    unique case (s_q.st)
      TX_IDLE: ;
      TX_SEND: begin
        if (s_q.left == 5'h00) begin
          s_d.st = TX_IDLE;
        end else begin
          if (s_q.pos == 4'h0) begin
            tx = 1'b0;
          end else if (s_q.pos <= 4'h8) begin
            tx = s_q.line[127 + 32'(s_q.pos)];
          end
          s_d.tmr = s_q.tmr + 17'h00001;
          if (s_q.tmr == BIT_LAST) begin
            s_d.tmr = '0;
            s_d.pos = s_q.pos + 4'h1;
            if (s_q.pos == POS_LAST) begin
              s_d.pos  = '0;
              s_d.line = {s_q.line[127:0], 8'h00};
              s_d.left = s_q.left - 5'h01;
              if (s_q.left == 5'h01) begin
                s_d.st    = TX_PAUSE;
                s_d.pause = 24'(PAUSE_CYC - 1);
              end
            end
          end
        end
      end
      TX_PAUSE: begin
        s_d.pause = s_q.pause - 24'h000001;
        if (s_q.pause == 24'h000000) begin
          s_d.st = TX_IDLE;
        end
      end
      default: s_d.st = TX_IDLE;
    endcase

    // Pin drive: select pins active low, serial stream inverted on pin zero
    s_d.pin_out[0] = s_q.pin_cfg[`PIN_SER_BIT] ? ~tx : ~s_q.pin_cfg[0];
    s_d.pin_out[3:1] = ~s_q.pin_cfg[3:1];
    s_d.pin_out[4]   = ~s_q.pin_cfg[`PIN_EN_BIT];
    s_d.pin_out[5]   = s_q.pin_cfg[`PIN_EN_BIT];

    if (rst_i) begin
      s_d         = '0;
      s_d.st      = TX_IDLE;
      s_d.pin_out = `PINS_RST;
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    s_q <= s_d;
  end

  assign wb_dat_o               = s_q.dat;
  assign wb_ack_o               = s_q.ack;
  assign link.chan_sel0_prog_in = s_q.pin_out[0];
  assign link.chan_sel1         = s_q.pin_out[1];
  assign link.chan_sel2         = s_q.pin_out[2];
  assign link.chan_sel3         = s_q.pin_out[3];
  assign link.transmit_enable_n = s_q.pin_out[4];
  assign link.receive_enable    = s_q.pin_out[5];

endmodule : radio_link_host
`default_nettype wire

// >>> radio_channel_config_cmd_monitor.sv
// Concurrent checks on the configuration link pins and the device status
`timescale 1ns/1ns
`default_nettype none
module radio_channel_config_cmd_monitor #(
  parameter int PROG_CYC = 50
) (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       chan_sel0_prog_in,
  input wire logic       transmit_enable_n,
  input wire logic [4:0] channel_o,
  input wire logic       operative_o,
  input wire logic       cmd_mode_o,
  input wire logic       prog_busy_o
);
  logic [23:0] busy_len_q;

  // Length of the current programming pause
  always_ff @(posedge clk_i) begin
    if (rst_i || !prog_busy_o) busy_len_q <= 24'h000000;
    else busy_len_q <= busy_len_q + 24'h000001;
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_reset_clear;
    $fell(rst_i) |-> channel_o == 5'h00 && !operative_o && !cmd_mode_o && !prog_busy_o;
  endproperty
  property p_tx_off;
    transmit_enable_n [*8] |-> !operative_o;
  endproperty
  property p_tx_on;
    $rose(operative_o) |-> !transmit_enable_n;
  endproperty
  property p_unlock_pin;
    $rose(cmd_mode_o) |-> !chan_sel0_prog_in && $past(chan_sel0_prog_in, 4) == 1'b0;
  endproperty
  property p_lock_pin;
    $fell(cmd_mode_o) |-> $stable(chan_sel0_prog_in) && !chan_sel0_prog_in;
  endproperty
  property p_busy_len;
    $fell(prog_busy_o) |-> busy_len_q == 24'(PROG_CYC);
  endproperty
  property p_busy_hold;
    $rose(prog_busy_o) |-> prog_busy_o [*8];
  endproperty
  property p_busy_unlocked;
    $rose(prog_busy_o) |-> cmd_mode_o;
  endproperty
  property p_busy_enabled;
    $rose(prog_busy_o) |-> $past(transmit_enable_n, 6) == 1'b0;
  endproperty

  // Checks on status and pins
  a_reset_clear: assert property (p_reset_clear) else $error("status not clear after reset");
  a_tx_off: assert property (p_tx_off) else $error("operative while disabled");
  a_tx_on: assert property (p_tx_on) else $error("became operative while disabled");
  a_unlock_pin: assert property (p_unlock_pin) else $error("unlock outside stop bit");
  a_lock_pin: assert property (p_lock_pin) else $error("lock outside stop bit");
  a_busy_len: assert property (p_busy_len) else $error("wrong programming pause");
  a_busy_hold: assert property (p_busy_hold) else $error("programming pause cut short");
  a_busy_unlocked: assert property (p_busy_unlocked) else $error("store while locked");
  a_busy_enabled: assert property (p_busy_enabled) else $error("store while disabled");

  // Main scenarios reached
  c_unlock: cover property ($rose(cmd_mode_o));
  c_busy: cover property ($fell(prog_busy_o));
  c_tx_on: cover property ($rose(operative_o));
endmodule : radio_channel_config_cmd_monitor
`default_nettype wire

// >>> radio_channel_config_cmd_bench.sv
// Self-checking bench: host and device joined over the configuration link
`include "radio_link_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module radio_channel_config_cmd_bench;
  typedef struct packed {
    logic [3:0]  k;
    logic [27:0] a;
    logic [5:0]  c;
    logic [15:0] n;
    logic [13:0] r;
  } row_t;
  localparam logic [15:0] N0 = `N_CH0_TX;
  localparam logic [13:0] RF = `R_TX;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        fact = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [3:0]  sel = 4'hF;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic        ack;
  logic [4:0]  ch;
  logic [15:0] n;
  logic [13:0] r;
  logic        opr;
  logic        cmd;
  logic        busy;
  int          error_cnt = 0;
  int          cmp_count = 0;
  // Command, argument (BCD), channel (bit 5 = skip), divider N, divider R
  row_t rows [10] = '{
    '{4'h1, 28'h0000005, 6'h05, N0 - 16'h0001, RF},
    '{4'h1, 28'h0000031, 6'h1F, N0 + 16'h0003, RF},
    '{4'h2, 28'h1234503, 6'h1F, N0 + 16'h0003, RF},
    '{4'h1, 28'h0000003, 6'h03, 16'h3039, RF},
    '{4'h5, 28'h1638300, 6'h03, 16'h3039, 14'h3FFF},
    '{4'h5, 28'h1638400, 6'h03, 16'h3039, 14'h3FFF},
    '{4'h1, 28'h0000032, 6'h03, 16'h3039, 14'h3FFF},
    '{4'h4, 28'h0000000, 6'h03, 16'h3039, 14'h3FFF},
    '{4'h6, 28'h6553600, 6'h03, 16'h3039, 14'h3FFF},
    '{4'h6, 28'h6553500, 6'h20, 16'hFFFF, 14'h3FFF}
  };

  radio_link_if lnk ();
  radio_link_host #(.BIT_CYC(16), .PAUSE_CYC(50)) radio_link_host_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .link(lnk));
  radio_link_device #(.BIT_CYC(16), .PROG_CYC(50)) radio_link_device_inst (
    .clk_i(clk_i), .rst_i(rst_i), .factory_load_i(fact), .link(lnk), .channel_o(ch),
    .n_div_o(n), .r_div_o(r), .operative_o(opr), .cmd_mode_o(cmd), .prog_busy_o(busy));
  radio_channel_config_cmd_monitor #(.PROG_CYC(50)) mon (
    .clk_i(clk_i), .rst_i(rst_i), .chan_sel0_prog_in(lnk.chan_sel0_prog_in),
    .transmit_enable_n(lnk.transmit_enable_n), .channel_o(ch), .operative_o(opr),
    .cmd_mode_o(cmd), .prog_busy_o(busy));

  // 100 MHz clock
  always #5 clk_i = ~clk_i;

  // Report counts and verdict, then stop
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  // Count a comparison and report a mismatch
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %0h exp %0h", $time, got, exp);
    end
  endtask : chk

  // One classic Wishbone cycle; read data taken at the ack edge
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  // Issue one command and wait until sending and pause are over
  task automatic send(input logic [3:0] k, input logic [27:0] a);
    wb(1'b1, `REG_ARG, {4'h0, a});
    wb(1'b1, `REG_CMD, {28'h0, k});
    q = 32'h1;
    while (q[0] !== 1'b0) wb(1'b0, `REG_STATUS, 32'h0);
  endtask : send

  // Set the pin register; wait out a stray frame the receiver may be in
  task automatic pins(input logic [5:0] p);
    wb(1'b1, `REG_PINS, {26'h0, p});
    repeat (200) @(posedge clk_i);
  endtask : pins

  // Main sequence
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    fact <= 1'b1;
    @(posedge clk_i);
    fact <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, 4'h2, 32'h0);
    chk(q, 32'h0);
    pins(6'h30);
    chk(32'({opr, ch, n}), {10'h0, 1'b1, 5'h01, N0 + 16'h0001});
    send(4'h0, 28'h0);
    chk(32'(cmd), 32'h1);
    foreach (rows[i]) begin
      send(rows[i].k, rows[i].a);
      if (!rows[i].c[5]) chk(32'(ch), 32'(rows[i].c[4:0]));
      chk(32'(n), 32'(rows[i].n));
      chk(32'(r), 32'(rows[i].r));
    end
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    pins(6'h30);
    chk(32'(opr), 32'h0);
    send(4'h1, 28'h7);
    chk(32'(ch == 5'h07), 32'h0);
    send(4'h0, 28'h0);
    send(4'h4, 28'h0);
    chk({ch, n, 10'h0, opr}, {5'h03, 16'h3039, 11'h001});
    send(4'h7, 28'h0);
    chk(32'(cmd), 32'h0);
    send(4'h1, 28'h9);
    chk(32'(ch), 32'h3);
    send(4'h0, 28'h0);
    send(4'h3, 28'h0);
    pins(6'h1A);
    chk(32'({ch, n}), 32'({5'h0A, N0 + 16'h0003}));
    pins(6'h20);
    chk(32'(opr), 32'h0);
    send(4'h1, 28'h6);
    pins(6'h30);
    chk(32'({opr, ch, n}), {10'h0, 1'b1, 5'h01, N0 + 16'h0001});
    end_sim();
  end

  // Watchdog against a hang
  initial begin
    #600000;
    error_cnt++;
    end_sim();
  end
endmodule : radio_channel_config_cmd_bench
`default_nettype wire
